// file: ddrsp_ctl_model.sv
// memory-controller model: pin clocks, commands and write data for the port
`timescale 1ns/100ps
`default_nettype none
`include "ddrsp_defines.vh"
module ddrsp_ctl_model (
	// clock and output clock enable
	input wire logic clk,
	input wire logic c_run,
	// pin clocks
	output logic k,
	output logic k_n,
	output logic c,
	output logic c_n,
	// command and write data
	output logic load_strobe_n,
	output logic read_not_write,
	output logic [`DDRSP_ADDR_W-1:1] addr_hi,
	output logic burst_lsb_address,
	output logic [`DDRSP_LANES-1:0] lanes,
	output logic [`DDRSP_DATA_W-1:0] dq_drive,
	// read side
	input wire logic [`DDRSP_DATA_W-1:0] dq_out_q,
	input wire logic dq_oe_n_q
);
	logic [3:0] ph = 4'h0;
	// k half period of six cycles keeps the port's fetch and drain ahead of the pins
	always @(posedge clk) begin
		ph <= (ph == 4'hB) ? 4'h0 : ph + 4'h1;
	end
	// c follows k; it stands low when switched off for single clock mode
	assign k = (ph < 4'h6);
	assign k_n = !k;
	assign c = c_run & k;
	assign c_n = c_run & !k;

	// idle command lines at time zero
	initial begin
		load_strobe_n = 1'b1;
		read_not_write = 1'b0;
		{addr_hi, burst_lsb_address} = 21'h000000;
		lanes = 4'hF;
		dq_drive = 36'h000000000;
	end

	// one burst: command across a k rise, write word0 at k_n rise, word1 at next k rise
	task automatic burst(input logic rnw, input logic [20:0] a, input logic [35:0] d0, d1,
		input logic [3:0] l0, l1, input int lat,
		output logic [35:0] r0, r1, output logic [2:0] oe);
		int n;
		int w;
		bit lost;
		// bounded phase waits; a lost phase spoils the oe result so the bench fails
		w = 0;
		do begin
			@(posedge clk);
			w++;
		end while (ph != 4'h8 && w < 12);
		lost = (ph != 4'h8);
		load_strobe_n <= 1'b0;
		read_not_write <= rnw;
		{addr_hi, burst_lsb_address} <= a;
		w = 0;
		do begin
			@(posedge clk);
			w++;
		end while (ph != 4'hB && w < 12);
		lost = lost | (ph != 4'hB);
		for (n = 1; n <= lat + 19; n++) begin
			@(posedge clk);
			// released lines carry junk, which the port must ignore
			if (n == 3) begin
				load_strobe_n <= 1'b1;
				read_not_write <= !rnw;
				{addr_hi, burst_lsb_address} <= ~a;
			end
			if (!rnw && n == 3)
				{dq_drive, lanes} <= {d0, l0};
			if (!rnw && n == 9)
				{dq_drive, lanes} <= {d1, l1};
			if (!rnw && n == 15)
				{dq_drive, lanes} <= ~{d1, l1};
			if (n == lat + 7)
				{r0, oe[0]} = {dq_out_q, dq_oe_n_q};
			if (n == lat + 13)
				{r1, oe[1]} = {dq_out_q, dq_oe_n_q};
			if (n == lat + 19)
				oe[2] = dq_oe_n_q;
		end
		// a pattern no transfer can give, so every caller's oe compare trips
		if (lost)
			oe = 3'b010;
	endtask
endmodule // ddrsp_ctl_model
`default_nettype wire

// file: ddrsp_defines.vh
// constants shared by the burst-of-two ddr sram port and its helpers
`ifndef DDRSP_DEFINES_VH
`define DDRSP_DEFINES_VH

// geometry of the wide variant
`define DDRSP_DATA_W 36
`define DDRSP_ADDR_W 21
`define DDRSP_LANES 4
`define DDRSP_LANE_W 9
`define DDRSP_WORDS_PER_BURST 2

// write buffer between pin capture and the array
`define DDRSP_FIFO_DEPTH 4
`define DDRSP_FIFO_AW 2
`define DDRSP_FIFO_W 61
`define DDRSP_LVL_W 3
`define DDRSP_FIFO_ROOM 3'h2

// write capture phases
`define DDRSP_WR_IDLE 2'h0
`define DDRSP_WR_WORD0 2'h1
`define DDRSP_WR_WORD1 2'h2

// read array sequencer steps
`define DDRSP_RD_IDLE 2'h0
`define DDRSP_RD_WORD0 2'h1
`define DDRSP_RD_WORD1 2'h2

// output-clock edges counted from the command to the first read word
`define DDRSP_FIRST_EDGE_PLL 3'h3
`define DDRSP_FIRST_EDGE_LEGACY 3'h2
`define DDRSP_CNT_W 3
`define DDRSP_CNT_ONE 3'h1
`define DDRSP_CNT_ZERO 3'h0
`define DDRSP_SLOTS 2

`endif

// file: ddrsp_fifo.v
// small write buffer with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
`include "ddrsp_defines.vh"

module ddrsp_fifo #(
	parameter WIDTH = `DDRSP_FIFO_W,
	parameter DEPTH = `DDRSP_FIFO_DEPTH,
	parameter AW = `DDRSP_FIFO_AW
) (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// fill side
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	// drain side
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data,
	// occupancy
	output wire [AW:0] level
);
	reg [WIDTH-1:0] store_q [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_q;
	reg [AW-1:0] rd_ptr_q;
	reg [AW:0] count_q;
	wire push;
	wire pop;

	assign in_ready = (count_q != DEPTH[AW:0]);
	assign out_valid = (count_q != {(AW+1){1'b0}});
	assign out_data = store_q[rd_ptr_q];
	assign level = count_q;
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// storage is not reset; only pointers and count carry control state
	always @(posedge clk) begin
		if (push) begin
			store_q[wr_ptr_q] <= in_data;
		end
	end

	// pointers wrap naturally because depth is a power of two
	always @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
			end
			if (push && !pop) begin
				count_q <= count_q + {{AW{1'b0}}, 1'b1};
			end else if (pop && !push) begin
				count_q <= count_q - {{AW{1'b0}}, 1'b1};
			end
		end
	end
endmodule // ddrsp_fifo
`default_nettype wire

// file: ddrsp_mem.v
// single-port storage array with per-lane write enables and registered read
`timescale 1ns/100ps
`default_nettype none
`include "ddrsp_defines.vh"

module ddrsp_mem (
	// clock
	input wire clk,
	// shared address; read wins if both strobes are high
	input wire [`DDRSP_ADDR_W-1:0] addr,
	input wire rd_en,
	input wire wr_en,
	input wire [`DDRSP_LANES-1:0] wr_lane_en,
	input wire [`DDRSP_DATA_W-1:0] wr_data,
	// read result, one cycle after rd_en
	output reg [`DDRSP_DATA_W-1:0] rd_data_q
);
	reg [`DDRSP_DATA_W-1:0] arr [0:(1<<`DDRSP_ADDR_W)-1];
	integer i;

	// lanes whose enable is low keep their old contents
	always @(posedge clk) begin
		if (rd_en) begin
			rd_data_q <= arr[addr];
		end else if (wr_en) begin
			for (i = 0; i < `DDRSP_LANES; i = i + 1) begin
				if (wr_lane_en[i]) begin
					arr[addr][i*`DDRSP_LANE_W +: `DDRSP_LANE_W] <=
						wr_data[i*`DDRSP_LANE_W +: `DDRSP_LANE_W];
				end
			end
		end
	end
endmodule // ddrsp_mem
`default_nettype wire

// file: ddrsp_port.v
// device side of a burst-of-two double-data-rate sram pin interface
`timescale 1ns/100ps
`default_nettype none
`include "ddrsp_defines.vh"

module ddrsp_port (
	// clock and reset
	input wire clk,
	input wire rst_n,
	// input and output clock pins
	input wire k,
	input wire k_n,
	input wire c,
	input wire c_n,
	// static mode pins
	input wire single_clock_mode,
	input wire pll_disable_n,
	// command pins
	input wire load_strobe_n,
	input wire read_not_write,
	input wire [`DDRSP_ADDR_W-1:1] addr_hi,
	input wire burst_lsb_address,
	input wire [`DDRSP_LANES-1:0] byte_lane_write_select_n,
	// shared data pins, split into the three signals of a two-way pin
	input wire [`DDRSP_DATA_W-1:0] dq_in,
	output reg [`DDRSP_DATA_W-1:0] dq_out_q,
	output reg dq_oe_n_q,
	// echo clocks
	output reg echo_strobe_q,
	output reg echo_strobe_n_q,
	// back-pressure: new write commands are refused while high
	output reg write_busy_q
);
	// two-flop synchronisers for every pin
	reg k_s1_q, k_s2_q, kn_s1_q, kn_s2_q, c_s1_q, c_s2_q, cn_s1_q, cn_s2_q;
	reg scm_s1_q, scm_s2_q, pll_s1_q, pll_s2_q, ld_n_s1_q, ld_n_s2_q;
	reg rnw_s1_q, rnw_s2_q;
	reg [`DDRSP_ADDR_W-1:0] addr_s1_q, addr_s2_q;
	reg [`DDRSP_LANES-1:0] bws_n_s1_q, bws_n_s2_q;
	reg [`DDRSP_DATA_W-1:0] dq_s1_q, dq_s2_q;
	// previous synchronised clock levels, for edge detection
	reg k_prev_q, kn_prev_q, c_prev_q, cn_prev_q;

	// edge events
	wire k_rise, kn_rise, c_rise, cn_rise;
	wire o_true_rise, o_comp_rise, out_edge;

	// write capture state
	reg [1:0] wr_phase_q;
	reg [`DDRSP_ADDR_W-1:0] wr_addr_q;
	reg fifo_push;
	reg [`DDRSP_FIFO_W-1:0] fifo_in;
	wire fifo_in_ready, fifo_out_valid;
	wire [`DDRSP_FIFO_W-1:0] fifo_out;
	wire [`DDRSP_LVL_W-1:0] fifo_level;
	reg [`DDRSP_LVL_W-1:0] wr_pend;
	wire wr_room;
	wire cmd_write, cmd_read;

	// read sequencer and slots
	reg [1:0] rd_step_q;
	reg rd_slot_q;
	reg [`DDRSP_ADDR_W-1:0] rd_addr_q;
	reg cap0_q, cap1_q, cap_slot_q;
	reg alloc_q;
	reg [`DDRSP_SLOTS-1:0] slot_v_q;
	reg [`DDRSP_CNT_W-1:0] slot_cnt_q [0:`DDRSP_SLOTS-1];
	reg [`DDRSP_DATA_W-1:0] slot_w0_q [0:`DDRSP_SLOTS-1];
	reg [`DDRSP_DATA_W-1:0] slot_w1_q [0:`DDRSP_SLOTS-1];
	wire [`DDRSP_CNT_W-1:0] first_edge;
	reg drv_hit;
	reg [`DDRSP_DATA_W-1:0] drv_word;
	reg [`DDRSP_SLOTS-1:0] slot_done;

	// array port
	wire mem_rd_en;
	wire [`DDRSP_ADDR_W-1:0] mem_addr;
	wire [`DDRSP_DATA_W-1:0] mem_rd_data;
	integer i;
	integer j;

	// rising edge seen between two synchronised samples
	function rise;
		input prev;
		input now;
		begin
			rise = now & ~prev;
		end
	endfunction

	// burst counter: advance the low bit, wrapping inside the word pair
	function [`DDRSP_ADDR_W-1:0] burst_next;
		input [`DDRSP_ADDR_W-1:0] a;
		begin
			burst_next = {a[`DDRSP_ADDR_W-1:1], ~a[0]};
		end
	endfunction

	// all pins pass two flops; clocks get a third stage only for the edge compare.
	// no reset here: a pin clock already high at release must not look like a fresh edge
	always @(posedge clk) begin
		k_s1_q <= k;
		k_s2_q <= k_s1_q;
		kn_s1_q <= k_n;
		kn_s2_q <= kn_s1_q;
		c_s1_q <= c;
		c_s2_q <= c_s1_q;
		cn_s1_q <= c_n;
		cn_s2_q <= cn_s1_q;
		scm_s1_q <= single_clock_mode;
		scm_s2_q <= scm_s1_q;
		pll_s1_q <= pll_disable_n;
		pll_s2_q <= pll_s1_q;
		ld_n_s1_q <= load_strobe_n;
		ld_n_s2_q <= ld_n_s1_q;
		rnw_s1_q <= read_not_write;
		rnw_s2_q <= rnw_s1_q;
		addr_s1_q <= {addr_hi, burst_lsb_address};
		addr_s2_q <= addr_s1_q;
		bws_n_s1_q <= byte_lane_write_select_n;
		bws_n_s2_q <= bws_n_s1_q;
		dq_s1_q <= dq_in;
		dq_s2_q <= dq_s1_q;
		k_prev_q <= k_s2_q;
		kn_prev_q <= kn_s2_q;
		c_prev_q <= c_s2_q;
		cn_prev_q <= cn_s2_q;
	end

	assign k_rise = rise(k_prev_q, k_s2_q);
	assign kn_rise = rise(kn_prev_q, kn_s2_q);
	assign c_rise = rise(c_prev_q, c_s2_q);
	assign cn_rise = rise(cn_prev_q, cn_s2_q);
	// single clock mode swaps the output pair for the input pair
	assign o_true_rise = scm_s2_q ? k_rise : c_rise;
	assign o_comp_rise = scm_s2_q ? kn_rise : cn_rise;
	assign out_edge = o_true_rise | o_comp_rise;

	// commands decode only on true input clock edges with the strobe low
	assign cmd_write = k_rise & ~ld_n_s2_q & ~rnw_s2_q & wr_room;
	assign cmd_read = k_rise & ~ld_n_s2_q & rnw_s2_q & ~slot_v_q[alloc_q];

	// words still owed to the buffer by an open write burst
	always @* begin
		case (wr_phase_q)
			`DDRSP_WR_WORD0: wr_pend = `DDRSP_FIFO_ROOM;
			`DDRSP_WR_WORD1: wr_pend = `DDRSP_LVL_W'h1;
			default: wr_pend = `DDRSP_LVL_W'h0;
		endcase
	end
	// a write is accepted only if both of its words are sure of a place
	assign wr_room = (fifo_level + wr_pend + `DDRSP_FIFO_ROOM) <=
		`DDRSP_FIFO_DEPTH;

	// write capture: word0 on the complement edge, word1 on the next true edge
	always @* begin
		fifo_push = 1'b0;
		fifo_in = {wr_addr_q, ~bws_n_s2_q, dq_s2_q};
		if (kn_rise && wr_phase_q == `DDRSP_WR_WORD0) begin
			fifo_push = fifo_in_ready;
		end else if (k_rise && wr_phase_q == `DDRSP_WR_WORD1) begin
			fifo_in = {burst_next(wr_addr_q), ~bws_n_s2_q, dq_s2_q};
			fifo_push = fifo_in_ready;
		end
	end

	// write phase machine; a new command may land on the edge of word1
	always @(posedge clk) begin
		if (!rst_n) begin
			wr_phase_q <= `DDRSP_WR_IDLE;
			wr_addr_q <= {`DDRSP_ADDR_W{1'b0}};
			write_busy_q <= 1'b0;
		end else begin
			write_busy_q <= ~wr_room;
			case (wr_phase_q)
				`DDRSP_WR_WORD0: begin
					if (kn_rise) begin
						wr_phase_q <= `DDRSP_WR_WORD1;
					end
				end
				`DDRSP_WR_WORD1: begin
					if (k_rise) begin
						wr_phase_q <= `DDRSP_WR_IDLE;
					end
				end
				default: wr_phase_q <= `DDRSP_WR_IDLE;
			endcase
			if (cmd_write) begin
				wr_addr_q <= addr_s2_q;
				wr_phase_q <= `DDRSP_WR_WORD0;
			end
		end
	end

	// buffer drains into the array whenever reads leave the port free
	ddrsp_fifo #(
		.WIDTH(`DDRSP_FIFO_W),
		.DEPTH(`DDRSP_FIFO_DEPTH),
		.AW(`DDRSP_FIFO_AW)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(fifo_push),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in),
		.out_valid(fifo_out_valid),
		.out_ready(~mem_rd_en),
		.out_data(fifo_out),
		.level(fifo_level)
	);

	assign mem_rd_en = (rd_step_q != `DDRSP_RD_IDLE);
	assign mem_addr = mem_rd_en ? rd_addr_q :
		fifo_out[`DDRSP_FIFO_W-1 -: `DDRSP_ADDR_W];

	// reads take priority so their fixed latency never slips
	ddrsp_mem u_mem (
		.clk(clk),
		.addr(mem_addr),
		.rd_en(mem_rd_en),
		.wr_en(fifo_out_valid),
		.wr_lane_en(fifo_out[`DDRSP_DATA_W +: `DDRSP_LANES]),
		.wr_data(fifo_out[`DDRSP_DATA_W-1:0]),
		.rd_data_q(mem_rd_data)
	);

	// read sequencer: two array reads back to back, then park the words
	always @(posedge clk) begin
		if (!rst_n) begin
			rd_step_q <= `DDRSP_RD_IDLE;
			rd_slot_q <= 1'b0;
			rd_addr_q <= {`DDRSP_ADDR_W{1'b0}};
			cap0_q <= 1'b0;
			cap1_q <= 1'b0;
			cap_slot_q <= 1'b0;
		end else begin
			cap0_q <= (rd_step_q == `DDRSP_RD_WORD0);
			cap1_q <= (rd_step_q == `DDRSP_RD_WORD1);
			cap_slot_q <= rd_slot_q;
			case (rd_step_q)
				`DDRSP_RD_WORD0: begin
					rd_step_q <= `DDRSP_RD_WORD1;
					rd_addr_q <= burst_next(rd_addr_q);
				end
				`DDRSP_RD_WORD1: rd_step_q <= `DDRSP_RD_IDLE;
				default: rd_step_q <= `DDRSP_RD_IDLE;
			endcase
			if (cmd_read) begin
				rd_step_q <= `DDRSP_RD_WORD0;
				rd_slot_q <= alloc_q;
				rd_addr_q <= addr_s2_q;
			end
		end
	end

	assign first_edge = pll_s2_q ? `DDRSP_FIRST_EDGE_PLL :
		`DDRSP_FIRST_EDGE_LEGACY;

	// pick the word due on this output edge; two slots cover overlapping bursts
	always @* begin
		drv_hit = 1'b0;
		drv_word = {`DDRSP_DATA_W{1'b0}};
		slot_done = {`DDRSP_SLOTS{1'b0}};
		for (i = 0; i < `DDRSP_SLOTS; i = i + 1) begin
			if (slot_v_q[i] && out_edge) begin
				if (slot_cnt_q[i] + `DDRSP_CNT_ONE == first_edge) begin
					drv_hit = 1'b1;
					drv_word = slot_w0_q[i];
				end else if (slot_cnt_q[i] == first_edge) begin
					drv_hit = 1'b1;
					drv_word = slot_w1_q[i];
					slot_done[i] = 1'b1;
				end
			end
		end
	end

	// slot bookkeeping: count output edges from the command onward
	always @(posedge clk) begin
		if (!rst_n) begin
			alloc_q <= 1'b0;
			slot_v_q <= {`DDRSP_SLOTS{1'b0}};
			for (j = 0; j < `DDRSP_SLOTS; j = j + 1) begin
				slot_cnt_q[j] <= `DDRSP_CNT_ZERO;
				slot_w0_q[j] <= {`DDRSP_DATA_W{1'b0}};
				slot_w1_q[j] <= {`DDRSP_DATA_W{1'b0}};
			end
		end else begin
			for (j = 0; j < `DDRSP_SLOTS; j = j + 1) begin
				if (slot_done[j]) begin
					slot_v_q[j] <= 1'b0;
				end else if (slot_v_q[j] && out_edge) begin
					slot_cnt_q[j] <= slot_cnt_q[j] + `DDRSP_CNT_ONE;
				end
			end
			if (cap0_q) begin
				slot_w0_q[cap_slot_q] <= mem_rd_data;
			end
			if (cap1_q) begin
				slot_w1_q[cap_slot_q] <= mem_rd_data;
			end
			if (cmd_read) begin
				slot_v_q[alloc_q] <= 1'b1;
				slot_cnt_q[alloc_q] <= `DDRSP_CNT_ZERO;
				alloc_q <= ~alloc_q;
			end
		end
	end

	// pin drivers change only on output clock edges; released when idle
	always @(posedge clk) begin
		if (!rst_n) begin
			dq_out_q <= {`DDRSP_DATA_W{1'b0}};
			dq_oe_n_q <= 1'b1;
			echo_strobe_q <= 1'b0;
			echo_strobe_n_q <= 1'b0;
		end else begin
			if (out_edge) begin
				dq_oe_n_q <= ~drv_hit;
				if (drv_hit) begin
					dq_out_q <= drv_word;
				end
			end
			// echo pair runs free, reads or not
			if (o_true_rise) begin
				echo_strobe_q <= 1'b1;
				echo_strobe_n_q <= 1'b0;
			end else if (o_comp_rise) begin
				echo_strobe_q <= 1'b0;
				echo_strobe_n_q <= 1'b1;
			end
		end
	end
endmodule // ddrsp_port
`default_nettype wire

// file: ddrsp_port_monitor.sv
// assertion checker for the burst-of-two ddr sram port pins
`timescale 1ns/100ps
`default_nettype none
`include "ddrsp_defines.vh"
module ddrsp_port_monitor (
	// clock, reset and pin clocks
	input wire logic clk,
	input wire logic rst_n,
	input wire logic k,
	input wire logic k_n,
	input wire logic c,
	input wire logic c_n,
	// modes and command
	input wire logic single_clock_mode,
	input wire logic pll_disable_n,
	input wire logic load_strobe_n,
	input wire logic read_not_write,
	input wire logic [`DDRSP_ADDR_W-1:1] addr_hi,
	input wire logic burst_lsb_address,
	input wire logic [`DDRSP_LANES-1:0] byte_lane_write_select_n,
	// data and status
	input wire logic [`DDRSP_DATA_W-1:0] dq_in,
	input wire logic [`DDRSP_DATA_W-1:0] dq_out_q,
	input wire logic dq_oe_n_q,
	input wire logic echo_strobe_q,
	input wire logic echo_strobe_n_q,
	input wire logic write_busy_q
);
	logic k_q, kn_q, c_q, cn_q, echo_q;
	logic [5:0] rd_age_q, echo_age_q;
	// pin edges seen here; the port reacts three to five cycles later because of its synchronisers
	wire logic tru_e = single_clock_mode ? (k & !k_q) : (c & !c_q);
	wire logic cmp_e = single_clock_mode ? (k_n & !kn_q) : (c_n & !cn_q);
	wire logic rd_cmd = k & !k_q & !load_strobe_n & read_not_write;

	// pin history plus ages since the last read command and the last echo change
	always @(posedge clk) begin
		k_q <= k;
		kn_q <= k_n;
		c_q <= c;
		cn_q <= c_n;
		echo_q <= echo_strobe_q;
		if (!rst_n)
			rd_age_q <= 6'h3F;
		else if (rd_cmd)
			rd_age_q <= 6'h00;
		else if (rd_age_q != 6'h3F)
			rd_age_q <= rd_age_q + 6'h01;
		if (!rst_n || echo_strobe_q != echo_q)
			echo_age_q <= 6'h00;
		else if (echo_age_q != 6'h3F)
			echo_age_q <= echo_age_q + 6'h01;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	dq_edge_a: assert property (($changed(dq_out_q) || $changed(dq_oe_n_q)) |->
		($past(tru_e, 3) || $past(tru_e, 4) || $past(tru_e, 5) || $past(cmp_e, 3) ||
		$past(cmp_e, 4) || $past(cmp_e, 5))) else $error("data pins moved off an output edge");
	echo_rise_a: assert property ($rose(echo_strobe_q) |->
		($past(tru_e, 3) || $past(tru_e, 4) || $past(tru_e, 5))) else $error("echo rose late");
	echo_fall_a: assert property ($fell(echo_strobe_q) |->
		($past(cmp_e, 3) || $past(cmp_e, 4) || $past(cmp_e, 5))) else $error("echo fell late");
	echo_pair_a: assert property ($changed(echo_strobe_n_q) |->
		echo_strobe_n_q != echo_strobe_q) else $error("echo pair not opposite");
	echo_alive_a: assert property (echo_age_q <= 6'h10)
		else $error("echo stopped running");
	burst_two_a: assert property ($fell(dq_oe_n_q) |-> !dq_oe_n_q [*8])
		else $error("read burst shorter than two words");
	oe_read_a: assert property (!dq_oe_n_q |-> rd_age_q <= 6'h28)
		else $error("data driven without a read");
	lat_pll_a: assert property (rd_cmd && dq_oe_n_q && pll_disable_n |->
		##[21:23] $fell(dq_oe_n_q)) else $error("pll read latency wrong");
	lat_legacy_a: assert property (rd_cmd && dq_oe_n_q && !pll_disable_n |->
		##[15:17] $fell(dq_oe_n_q)) else $error("legacy read latency wrong");

	// main scenarios reached
	cover property (rd_cmd && pll_disable_n && !single_clock_mode);
	cover property (rd_cmd && !pll_disable_n);
	cover property (rd_cmd && single_clock_mode);
endmodule // ddrsp_port_monitor
`default_nettype wire

// file: tb_ddr_burst2_sram_port.sv
// self-checking bench for the burst-of-two ddr sram port
`timescale 1ns/100ps
`default_nettype none
`include "ddrsp_defines.vh"
`define CHECK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin fails++; \
	$display("MISMATCH %s expected %h seen %h", what, exp, got); end end
module tb_ddr_burst2_sram_port;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic single_clock_mode = 1'b0;
	logic pll_disable_n = 1'b1;
	logic c_run = 1'b1;
	wire logic k, k_n, c, c_n, load_strobe_n, read_not_write, burst_lsb_address;
	wire logic dq_oe_n_q, echo_strobe_q, echo_strobe_n_q, write_busy_q;
	wire logic [19:0] addr_hi;
	wire logic [3:0] byte_lane_write_select_n;
	wire logic [35:0] dq_drive, dq_in, dq_out_q;
	int fails = 0;
	int total_checks = 0;
	localparam logic [20:0] ADR_A = 21'h0ABCD4;
	localparam logic [20:0] ADR_B = 21'h155552;
	localparam logic [35:0] WORD_0 = 36'h123456789;
	localparam logic [35:0] WORD_1 = 36'hFEDCBA987;

	// the shared data wire: the port wins while it drives
	assign dq_in = dq_oe_n_q ? dq_drive : dq_out_q;

	ddrsp_port i_dut (.clk, .rst_n, .k, .k_n, .c, .c_n, .single_clock_mode, .pll_disable_n,
		.load_strobe_n, .read_not_write, .addr_hi, .burst_lsb_address,
		.byte_lane_write_select_n, .dq_in, .dq_out_q, .dq_oe_n_q, .echo_strobe_q,
		.echo_strobe_n_q, .write_busy_q);
	ddrsp_ctl_model i_ctl (.clk, .c_run, .k, .k_n, .c, .c_n, .load_strobe_n,
		.read_not_write, .addr_hi, .burst_lsb_address, .lanes(byte_lane_write_select_n),
		.dq_drive, .dq_out_q, .dq_oe_n_q);

	// 250 MHz clock
	initial begin
		forever #2 clk = ~clk;
	end

	task automatic summarize;
		if (fails == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// mode pins are static, so they only change under reset
	task automatic do_reset(input logic pll, input logic single, input logic crun);
		@(posedge clk);
		rst_n <= 1'b0;
		pll_disable_n <= pll;
		single_clock_mode <= single;
		c_run <= crun;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
	endtask

	function automatic logic [35:0] merge(input logic [35:0] o, n, input logic [3:0] s);
		merge = o;
		for (int i = 0; i < 4; i++)
			if (!s[i])
				merge[9*i +: 9] = n[9*i +: 9];
	endfunction

	task automatic wr(input logic [20:0] a, input logic [35:0] d0, d1, input logic [3:0] l0, l1);
		logic [35:0] r0, r1;
		logic [2:0] oe;
		i_ctl.burst(1'b0, a, d0, d1, l0, l1, 0, r0, r1, oe);
		`CHECK("write keeps pins released", 3'b111, oe)
	endtask

	task automatic rd(input logic [20:0] a, input int lat, input logic [35:0] e0, e1);
		logic [35:0] r0, r1;
		logic [2:0] oe;
		i_ctl.burst(1'b1, a, 36'h000000000, 36'h000000000, 4'hF, 4'hF, lat, r0, r1, oe);
		`CHECK("first read word", e0, r0)
		`CHECK("second read word", e1, r1)
		`CHECK("output enable slots", 3'b100, oe)
	endtask

	task automatic t_reset;
		do_reset(1'b1, 1'b0, 1'b1);
		`CHECK("oe after reset", 1'b1, dq_oe_n_q)
		`CHECK("data after reset", 36'h000000000, dq_out_q)
		`CHECK("busy after reset", 1'b0, write_busy_q)
		`CHECK("echo after reset", 2'b00, {echo_strobe_q, echo_strobe_n_q})
	endtask

	// even address, then the odd one: order must wrap within the pair
	task automatic t_wr_rd;
		wr(ADR_A, WORD_0, WORD_1, 4'h0, 4'h0);
		rd(ADR_A, 18, WORD_0, WORD_1);
		rd(ADR_A | 21'h000001, 18, WORD_1, WORD_0);
	endtask

	// each word carries its own lane selects
	task automatic t_lanes;
		wr(ADR_B, ~36'h0, ~36'h0, 4'h0, 4'h0);
		wr(ADR_B, 36'h0, 36'h0, 4'hA, 4'h5);
		rd(ADR_B, 18, merge(~36'h0, 36'h0, 4'hA), merge(~36'h0, 36'h0, 4'h5));
	endtask

	task automatic t_legacy;
		do_reset(1'b0, 1'b0, 1'b1);
		rd(ADR_A, 12, WORD_0, WORD_1);
	endtask

	// output clocks stopped: read data and echoes must follow the input pair
	task automatic t_single;
		int n;
		logic e;
		do_reset(1'b1, 1'b1, 1'b0);
		rd(ADR_A, 18, WORD_0, WORD_1);
		n = 0;
		e = echo_strobe_q;
		repeat (24) begin
			@(posedge clk);
			if (echo_strobe_q !== e)
				n++;
			e = echo_strobe_q;
		end
		`CHECK("echo toggles", 4, n)
		`CHECK("echo pair opposite", ~echo_strobe_q, echo_strobe_n_q)
	endtask

	// watchdog against a hung run
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		summarize();
	end

	initial begin
		t_reset();
		t_wr_rd();
		t_lanes();
		t_legacy();
		t_single();
		summarize();
	end
endmodule // tb_ddr_burst2_sram_port

bind ddrsp_port ddrsp_port_monitor i_mon (.clk, .rst_n, .k, .k_n, .c, .c_n,
	.single_clock_mode, .pll_disable_n, .load_strobe_n, .read_not_write, .addr_hi,
	.burst_lsb_address, .byte_lane_write_select_n, .dq_in, .dq_out_q, .dq_oe_n_q,
	.echo_strobe_q, .echo_strobe_n_q, .write_busy_q);
`default_nettype wire
